// [inc/trip_pkg.sv]
// Shared constants for the trip sensing and lockout block
package trip_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int RESTORE_TIME_S = 2;
	localparam int WINDOW_TIME_S = 62;
	localparam int RESTORE_TICKS = RESTORE_TIME_S * 1000 * 1000 / TICK_TIME_US;
	localparam int WINDOW_TICKS = WINDOW_TIME_S * 1000 * 1000 / TICK_TIME_US;
	localparam int DEBOUNCE_TIME_US = 1000;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam logic [1:0] SHOT_LIMIT = 2'h3;
	// Trip vector positions
	localparam int NUM_TRIPS = 8;
	localparam int TRIP_CAB = 0;
	localparam int TRIP_AIR = 1;
	localparam int TRIP_BIAS = 2;
	localparam int TRIP_AUX = 3;
	localparam int TRIP_HT = 4;
	localparam int TRIP_SCREEN = 5;
	localparam int TRIP_CATHODE = 6;
	localparam int TRIP_REVPWR = 7;
	// Conditioned pin vector positions
	localparam int NUM_PINS = 12;
	localparam int PIN_BIAS = 0;
	localparam int PIN_AUX = 1;
	localparam int PIN_HT = 2;
	localparam int PIN_SCREEN = 3;
	localparam int PIN_CATHODE = 4;
	localparam int PIN_REVPWR = 5;
	localparam int PIN_THERMO = 6;
	localparam int PIN_AIRSW = 7;
	localparam int PIN_SEQ = 8;
	localparam int PIN_LRST = 9;
	localparam int PIN_ICLR = 10;
	localparam int PIN_SUPOK = 11;
	// Register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_LIVE = 4'h8;
	localparam int CTRL_DIRECT_HT_BIT = 0;
	localparam logic CTRL_DIRECT_HT_RESET = 1'b0;
	localparam int ST_IND_LSB = 0;
	localparam int ST_TRIP_BIT = 8;
	localparam int ST_LOCK_BIT = 9;
	localparam int ST_CAB_BIT = 10;
	localparam int ST_SHOT_LSB = 11;
	localparam int LIVE_TRIP_LSB = 0;
	localparam int LIVE_NOAIR_BIT = 8;
	localparam int LIVE_SEQ_BIT = 9;
endpackage

// [core/contact_conditioner.sv]
// Three-stage synchroniser and debounce filter for contact inputs
`timescale 1ns/1ps
module contact_conditioner
	import trip_pkg::*;
#(
	parameter int WIDTH = NUM_PINS,
	parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] raw,
	output logic [WIDTH-1:0] clean
);
	localparam int CW = $clog2(STABLE_CYCLES + 1);

	if (WIDTH < 1 || STABLE_CYCLES < 1) begin : g_check
		$error("contact_conditioner: WIDTH and STABLE_CYCLES must be at least 1");
	end

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] clean;
		logic [WIDTH-1:0][CW-1:0] cnt;
	} cond_type;

	cond_type st_reg;
	cond_type st_next;

	// Stage one feeds stage two only; stages two and three vote on a change
	always_comb begin
		st_next = st_reg;
		st_next.s1 = raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_reg.s2[i] == st_reg.s3[i] && st_reg.s3[i] != st_reg.clean[i]) begin
				if (st_reg.cnt[i] == CW'(STABLE_CYCLES - 1)) begin
					st_next.clean[i] = st_reg.s3[i];
					st_next.cnt[i] = '0;
				end else begin
					st_next.cnt[i] = st_reg.cnt[i] + 1'b1;
				end
			end else begin
				st_next.cnt[i] = '0;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign clean = st_reg.clean;
endmodule

// [core/trip_sense_lockout.sv]
// Trip sensing, three-shot restoration and lockout with Avalon-MM registers
`timescale 1ns/1ps
// What this block does
// - Watch eight trip sources: cabinet, air, bias, aux, HT, screen, cathode, reverse power.
// - Any sensed trip commands the high-tension supply off.
// - About two seconds after a trip, release the HT inhibit if clear.
// - Three restoration attempts; the next trip locks out until manual reset.
// - Cabinet over-temperature turns everything off and locks out directly.
// - Each trip lights its own indicator, held until manually cleared.
// - Optional setting: an HT supplies trip locks out after one trip.
// - Supplies-normal low clears indicators and lockout state.
// - Thermostat opening sets cabinet latch and raises high cabinet temperature command.
// - Cabinet latch feeds trip gate, sets lockout with trip sensed, lights indicator.
// - Cabinet latch clears on reclosed thermostat plus lockout reset or supplies-normal low.
// - Air status output mirrors airflow switch: high means no air.
// - Standby arms air-fail latch set; airflow closing clears it.
// - In standby no air-fail trip or indication is produced.
// - Airflow loss after closure with aux on trips and lights air indicator.
// - Persisting air failure keeps retriggering until lockout.
// - Airflow recovery withdraws the air trip; indicator stays lit.
// - Trip sensed drives the trip/lockout output high.
// - Restoration clears trip sensed only when no trip is then present.
// - 62 seconds without a restoration attempt clears the attempt counter.
module trip_sense_lockout
	import trip_pkg::*;
#(
	parameter int PRESCALE_CYCLES = TICK_CYCLES,
	parameter int RESTORE_COUNT = RESTORE_TICKS,
	parameter int WINDOW_COUNT = WINDOW_TICKS,
	parameter int STABLE_CYCLES = DEBOUNCE_CYCLES
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bias_fail_in,
	input wire logic aux_fail_in,
	input wire logic ht_trip_in,
	input wire logic screen_trip_in,
	input wire logic cathode_trip_in,
	input wire logic reverse_power_trip_in,
	input wire logic thermostat_in,
	input wire logic airflow_switch_in,
	input wire logic sequence_position_in,
	input wire logic lockout_reset_in,
	input wire logic indicator_clear_switch,
	input wire logic supplies_normal_in,
	output logic trip_lockout_out,
	output logic high_cabinet_temp_cmd,
	output logic air_status_out,
	output logic lockout_latched_state,
	output logic [NUM_TRIPS-1:0] fault_indicator
);
	localparam int PW = $clog2(PRESCALE_CYCLES + 1);
	localparam int RW = $clog2(RESTORE_COUNT + 1);
	localparam int WW = $clog2(WINDOW_COUNT + 1);

	if (PRESCALE_CYCLES < 1 || RESTORE_COUNT < 1 || WINDOW_COUNT < 1) begin : g_check
		$error("trip_sense_lockout: timer counts must be at least 1");
	end

	typedef struct packed {
		logic [NUM_TRIPS-1:0] ind;
		logic cab;
		logic air_shut;
		logic trip;
		logic lock;
		logic [1:0] shots;
		logic [PW-1:0] pre;
		logic [RW-1:0] rcnt;
		logic [WW-1:0] wcnt;
		logic win;
		logic lrst_q;
		logic iclr_q;
		logic direct;
		logic ht_off;
		logic cab_cmd;
		logic no_air_q;
		logic ack;
		logic [31:0] rdata;
	} state_type;

	state_type st_reg;
	state_type st_next;
	logic [NUM_PINS-1:0] pins_raw;
	logic [NUM_PINS-1:0] pins;
	logic [NUM_TRIPS-1:0] trips;
	logic any_trip;
	logic tick;
	logic shot;
	logic lrst_ev;
	logic iclr_ev;
	logic sup_clr;
	logic aux_on;
	logic no_air;
	logic air_fail;
	logic lock_set;
	logic bus_req;
	logic [31:0] rd_mux;

	assign pins_raw[PIN_BIAS] = bias_fail_in;
	assign pins_raw[PIN_AUX] = aux_fail_in;
	assign pins_raw[PIN_HT] = ht_trip_in;
	assign pins_raw[PIN_SCREEN] = screen_trip_in;
	assign pins_raw[PIN_CATHODE] = cathode_trip_in;
	assign pins_raw[PIN_REVPWR] = reverse_power_trip_in;
	assign pins_raw[PIN_THERMO] = thermostat_in;
	assign pins_raw[PIN_AIRSW] = airflow_switch_in;
	assign pins_raw[PIN_SEQ] = sequence_position_in;
	assign pins_raw[PIN_LRST] = lockout_reset_in;
	assign pins_raw[PIN_ICLR] = indicator_clear_switch;
	assign pins_raw[PIN_SUPOK] = supplies_normal_in;

	// Contacts bounce for milliseconds; nothing below sees a raw pin
	contact_conditioner #(
		.WIDTH(NUM_PINS),
		.STABLE_CYCLES(STABLE_CYCLES)
	) u_cond (
		.mclk(mclk),
		.arst_n(arst_n),
		.raw(pins_raw),
		.clean(pins)
	);

	assign sup_clr = ~pins[PIN_SUPOK];
	assign aux_on = pins[PIN_SEQ];
	assign no_air = pins[PIN_AIRSW];
	assign lrst_ev = pins[PIN_LRST] & ~st_reg.lrst_q;
	assign iclr_ev = pins[PIN_ICLR] & ~st_reg.iclr_q;
	// Air fail only once the switch has closed with auxiliaries on
	assign air_fail = aux_on & ~st_reg.air_shut & no_air;

	// A reset that clears the cabinet latch must not relock on the latch's stale value
	assign trips[TRIP_CAB] = st_reg.cab & ~(~pins[PIN_THERMO] & (lrst_ev | sup_clr));
	assign trips[TRIP_AIR] = air_fail;
	assign trips[TRIP_BIAS] = pins[PIN_BIAS];
	assign trips[TRIP_AUX] = pins[PIN_AUX];
	assign trips[TRIP_HT] = pins[PIN_HT];
	assign trips[TRIP_SCREEN] = pins[PIN_SCREEN];
	assign trips[TRIP_CATHODE] = pins[PIN_CATHODE];
	assign trips[TRIP_REVPWR] = pins[PIN_REVPWR];
	assign any_trip = |trips;

	assign tick = st_reg.pre == PW'(PRESCALE_CYCLES - 1);
	assign shot = st_reg.trip & tick & (st_reg.rcnt == RW'(RESTORE_COUNT - 1));
	assign lock_set = st_reg.trip & (trips[TRIP_CAB]
		| (st_reg.direct & trips[TRIP_HT])
		| (any_trip & (st_reg.shots == SHOT_LIMIT)));
	assign bus_req = avs_read | avs_write;

	always_comb begin
		rd_mux = '0;
		if (avs_address == REG_CTRL) begin
			rd_mux[CTRL_DIRECT_HT_BIT] = st_reg.direct;
		end else if (avs_address == REG_STATUS) begin
			rd_mux[ST_IND_LSB +: NUM_TRIPS] = st_reg.ind;
			rd_mux[ST_TRIP_BIT] = st_reg.trip;
			rd_mux[ST_LOCK_BIT] = st_reg.lock;
			rd_mux[ST_CAB_BIT] = st_reg.cab;
			rd_mux[ST_SHOT_LSB +: 2] = st_reg.shots;
		end else if (avs_address == REG_LIVE) begin
			rd_mux[LIVE_TRIP_LSB +: NUM_TRIPS] = trips;
			rd_mux[LIVE_NOAIR_BIT] = no_air;
			rd_mux[LIVE_SEQ_BIT] = aux_on;
		end
	end

	always_comb begin
		st_next = st_reg;
		st_next.pre = tick ? '0 : st_reg.pre + 1'b1;
		st_next.lrst_q = pins[PIN_LRST];
		st_next.iclr_q = pins[PIN_ICLR];
		st_next.no_air_q = no_air;
		// Standby re-arms; closure of the air switch disarms the shutdown latch
		if (!aux_on) begin
			st_next.air_shut = 1'b1;
		end else if (!no_air) begin
			st_next.air_shut = 1'b0;
		end
		// Thermostat opening wins over a simultaneous reset
		if (pins[PIN_THERMO]) begin
			st_next.cab = 1'b1;
		end else if (lrst_ev | sup_clr) begin
			st_next.cab = 1'b0;
		end
		// Indicators: new trips win over the clear
		if (iclr_ev | sup_clr) begin
			st_next.ind = trips;
		end else begin
			st_next.ind = st_reg.ind | trips;
		end
		// Restoration delay runs only while a trip is held
		if (!st_reg.trip) begin
			st_next.rcnt = '0;
		end else if (tick) begin
			st_next.rcnt = shot ? '0 : st_reg.rcnt + 1'b1;
		end
		if (any_trip) begin
			st_next.trip = 1'b1;
		end else if (shot | lrst_ev | sup_clr) begin
			st_next.trip = 1'b0;
		end
		// Attempt counter and its quiet window
		if (shot) begin
			st_next.win = 1'b1;
			st_next.wcnt = '0;
			if (st_reg.shots != SHOT_LIMIT) begin
				st_next.shots = st_reg.shots + 1'b1;
			end
		end else if (lrst_ev | sup_clr) begin
			st_next.win = 1'b0;
			st_next.shots = '0;
		end else if (st_reg.win & tick) begin
			if (st_reg.wcnt == WW'(WINDOW_COUNT - 1)) begin
				st_next.win = 1'b0;
				st_next.shots = '0;
			end else begin
				st_next.wcnt = st_reg.wcnt + 1'b1;
			end
		end
		if (lock_set) begin
			st_next.lock = 1'b1;
		end else if (lrst_ev | sup_clr) begin
			st_next.lock = 1'b0;
		end
		st_next.ht_off = st_next.trip | st_next.lock;
		st_next.cab_cmd = st_next.cab;
		// Bus: one wait cycle, read data captured in it, write applied after
		st_next.ack = bus_req & ~st_reg.ack;
		if (avs_read & ~st_reg.ack) begin
			st_next.rdata = rd_mux;
		end
		if (avs_write & st_reg.ack & (avs_address == REG_CTRL) & avs_byteenable[0]) begin
			st_next.direct = avs_writedata[CTRL_DIRECT_HT_BIT];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.air_shut <= 1'b1;
			st_reg.direct <= CTRL_DIRECT_HT_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign avs_waitrequest = bus_req & ~st_reg.ack;
	assign avs_readdata = st_reg.rdata;
	assign trip_lockout_out = st_reg.ht_off;
	assign high_cabinet_temp_cmd = st_reg.cab_cmd;
	assign air_status_out = st_reg.no_air_q;
	assign lockout_latched_state = st_reg.lock;
	assign fault_indicator = st_reg.ind;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence s_restore_clear;
		shot && !any_trip;
	endsequence

	sequence s_released;
		!st_reg.trip ##0 (trip_lockout_out == st_reg.lock);
	endsequence

	sequence s_bus_wait;
		bus_req && avs_waitrequest;
	endsequence

	a_trip_sets_sensed: assert property (any_trip |=> st_reg.trip && trip_lockout_out)
		else $error("trip did not assert the HT off command");
	a_restore_release: assert property (s_restore_clear |=> s_released)
		else $error("restoration did not release the inhibit");
	a_restore_hold: assert property (shot && any_trip |=> st_reg.trip)
		else $error("restoration released with a trip present");
	a_shot_lockout: assert property (st_reg.trip && any_trip && st_reg.shots == 2'h3
		|=> lockout_latched_state && trip_lockout_out)
		else $error("fourth trip did not lock out");
	a_cab_lockout: assert property (trips[TRIP_CAB] && st_reg.trip |=> st_reg.lock)
		else $error("cabinet trip did not lock out directly");
	a_cab_command: assert property (pins[PIN_THERMO] |=> st_reg.cab && high_cabinet_temp_cmd)
		else $error("open thermostat did not raise the cabinet command");
	a_cab_hold: assert property (st_reg.cab && !lrst_ev && !sup_clr |=> st_reg.cab)
		else $error("cabinet latch cleared without a lockout reset");
	a_ind_hold: assert property (!iclr_ev && !sup_clr
		|=> (fault_indicator & $past(fault_indicator)) == $past(fault_indicator))
		else $error("fault indicator dropped without a clear");
	a_direct_ht: assert property (st_reg.direct && pins[PIN_HT] && st_reg.trip
		|=> lockout_latched_state)
		else $error("direct HT lockout option ignored");
	a_supply_clear: assert property (sup_clr && !lock_set |=> !lockout_latched_state)
		else $error("supplies-normal low did not clear lockout");
	a_air_status: assert property (##1 air_status_out == $past(no_air))
		else $error("air status does not follow the airflow switch");
	a_standby_quiet: assert property (!aux_on && !fault_indicator[TRIP_AIR]
		|=> !fault_indicator[TRIP_AIR])
		else $error("air fail raised in standby");
	a_air_indicate: assert property (air_fail |=> st_reg.trip && fault_indicator[TRIP_AIR])
		else $error("air failure not tripped and indicated");
	a_window_clear: assert property (st_reg.win && tick && !shot && !lrst_ev && !sup_clr
		&& st_reg.wcnt == WW'(WINDOW_COUNT - 1) |=> st_reg.shots == 2'h0)
		else $error("attempt counter not cleared after the quiet window");
	a_bus_answer: assert property (s_bus_wait |=> !avs_waitrequest)
		else $error("bus answer took more than one wait cycle");
endmodule

// [dv/supplies_model.sv]
// Supplies controller model: power-up clear pulse and HT enable
`timescale 1ns/1ps
module supplies_model (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic restart,
	input wire logic trip_lockout_out,
	input wire logic high_cabinet_temp_cmd,
	input wire logic air_status_out,
	output logic supplies_normal_in,
	output logic ht_on
);
	logic [4:0] hold_reg;
	// Clear period outlasts the input debounce, or the block would never see it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			hold_reg <= 5'h14;
		end else if (restart) begin
			hold_reg <= 5'h14;
		end else if (hold_reg != 5'h0) begin
			hold_reg <= hold_reg - 5'h1;
		end
	end
	assign supplies_normal_in = (hold_reg == 5'h0);
	assign ht_on = ~trip_lockout_out & ~high_cabinet_temp_cmd & ~air_status_out;
endmodule

// [dv/tb_trip_sense_lockout.sv]
// Self-checking bench for the trip sensing and lockout block
`timescale 1ns/1ps
module tb_trip_sense_lockout;
	import trip_pkg::*;
	logic mclk, arst_n, rd, wr, restart, thermo, airsw, seq, lrst, iclr;
	logic [3:0] addr, be;
	logic [31:0] wdata, rdata, d;
	logic [5:0] trips;
	logic wreq, tlo, hcab, airst, lock, supok, ht_on;
	logic [7:0] ind;
	logic [7:0] row_exp [6] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
	int err_count, checks, r;
	trip_sense_lockout #(.PRESCALE_CYCLES(4), .RESTORE_COUNT(5), .WINDOW_COUNT(20),
		.STABLE_CYCLES(2)) i_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(addr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .bias_fail_in(trips[0]),
		.aux_fail_in(trips[1]), .ht_trip_in(trips[2]), .screen_trip_in(trips[3]),
		.cathode_trip_in(trips[4]), .reverse_power_trip_in(trips[5]),
		.thermostat_in(thermo), .airflow_switch_in(airsw), .sequence_position_in(seq),
		.lockout_reset_in(lrst), .indicator_clear_switch(iclr), .supplies_normal_in(supok),
		.trip_lockout_out(tlo), .high_cabinet_temp_cmd(hcab), .air_status_out(airst),
		.lockout_latched_state(lock), .fault_indicator(ind));
	supplies_model i_supplies (.mclk(mclk), .arst_n(arst_n), .restart(restart),
		.trip_lockout_out(tlo), .high_cabinet_temp_cmd(hcab), .air_status_out(airst),
		.supplies_normal_in(supok), .ht_on(ht_on));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task end_of_test;
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function logic pick(input int k);
		case (k)
			0: return tlo;
			1: return lock;
			2: return airst;
			default: return hcab;
		endcase
	endfunction
	// Bounded wait on an output; running out ends the run
	task wait_out(input int k, input logic v, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(negedge mclk);
			if (pick(k) === v) break;
		end
		cmp({31'h0, pick(k)}, {31'h0, v});
		if (i == n) end_of_test;
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] v);
		int i;
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		rd <= !w;
		wr <= w;
		for (i = 0; i < 50; i++) begin
			@(negedge mclk);
			if (wreq === 1'b0) break;
		end
		if (i == 50) begin
			err_count++;
			end_of_test;
		end
		@(posedge mclk);
		d = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task setp(input int k, input logic v);
		@(posedge mclk);
		if (k < 6) trips[k] <= v;
		else if (k == 6) thermo <= v;
		else if (k == 7) airsw <= v;
		else seq <= v;
	endtask
	// Switch pulses are held well past the debounce time
	task pulse(input int k);
		@(posedge mclk);
		if (k == 0) lrst <= 1'b1;
		else iclr <= 1'b1;
		repeat (12) @(posedge mclk);
		lrst <= 1'b0;
		iclr <= 1'b0;
		repeat (12) @(posedge mclk);
	endtask
	task idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	initial begin
		{rd, wr, restart, thermo, seq, lrst, iclr} = '0;
		{arst_n, addr, wdata, trips, err_count, checks} = '0;
		airsw = 1'b1;
		be = 4'hf;
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		@(negedge mclk);
		cmp({tlo, lock, hcab, airst, ind}, 12'h0);
		idle(50);
		cmp(airst, 1'b1);
		setp(7, 1'b0);
		wait_out(2, 1'b0, 40);
		$display("reset test done");
		for (r = 0; r < 6; r++) begin
			setp(r, 1'b1);
			wait_out(0, 1'b1, 60);
			cmp(ht_on, 1'b0);
			setp(r, 1'b0);
			wait_out(0, 1'b0, 100);
			cmp(ht_on, 1'b1);
			cmp(ind, row_exp[r]);
			pulse(0);
			pulse(1);
			cmp(ind, 8'h0);
			$display("row %0d done", r);
		end
		setp(1, 1'b1);
		setp(1, 1'b0);
		idle(30);
		cmp({tlo, ind}, 9'h0);
		bus(0, REG_CTRL, 32'h0);
		cmp(d, 32'h0);
		bus(1, REG_CTRL, 32'h1);
		be <= 4'he;
		bus(1, REG_CTRL, 32'h0);
		be <= 4'hf;
		bus(0, REG_CTRL, 32'h0);
		cmp(d, 32'h1);
		bus(0, 4'hc, 32'h0);
		cmp(d, 32'h0);
		setp(2, 1'b1);
		wait_out(1, 1'b1, 60);
		setp(2, 1'b0);
		idle(30);
		cmp(lock, 1'b1);
		pulse(0);
		wait_out(1, 1'b0, 40);
		pulse(1);
		bus(1, REG_CTRL, 32'h0);
		$display("direct lockout test done");
		setp(0, 1'b1);
		wait_out(0, 1'b1, 60);
		idle(30);
		cmp(lock, 1'b0);
		wait_out(1, 1'b1, 300);
		bus(0, REG_STATUS, 32'h0);
		cmp(d[12:0], 13'h1b04);
		setp(0, 1'b0);
		idle(20);
		pulse(0);
		wait_out(1, 1'b0, 40);
		wait_out(0, 1'b0, 40);
		pulse(1);
		setp(0, 1'b1);
		wait_out(0, 1'b1, 60);
		setp(0, 1'b0);
		wait_out(0, 1'b0, 100);
		bus(0, REG_STATUS, 32'h0);
		cmp(d[12:11], 2'h1);
		idle(120);
		bus(0, REG_STATUS, 32'h0);
		cmp(d[12:11], 2'h0);
		pulse(1);
		$display("three shot test done");
		setp(6, 1'b1);
		wait_out(3, 1'b1, 60);
		wait_out(1, 1'b1, 20);
		cmp(ind, 8'h01);
		pulse(0);
		cmp(lock, 1'b1);
		setp(6, 1'b0);
		idle(20);
		cmp(hcab, 1'b1);
		pulse(0);
		wait_out(3, 1'b0, 40);
		wait_out(1, 1'b0, 40);
		cmp(ind, 8'h01);
		pulse(1);
		cmp(ind, 8'h0);
		$display("cabinet test done");
		setp(7, 1'b1);
		wait_out(2, 1'b1, 40);
		setp(8, 1'b1);
		idle(20);
		cmp(tlo, 1'b0);
		setp(7, 1'b0);
		wait_out(2, 1'b0, 40);
		setp(7, 1'b1);
		wait_out(0, 1'b1, 60);
		cmp({airst, ind}, 9'h102);
		idle(40);
		cmp(tlo, 1'b1);
		setp(7, 1'b0);
		wait_out(0, 1'b0, 100);
		cmp({airst, ind}, 9'h002);
		pulse(0);
		pulse(1);
		setp(8, 1'b0);
		setp(7, 1'b1);
		idle(60);
		cmp({tlo, ind}, 9'h0);
		$display("air test done");
		setp(6, 1'b1);
		wait_out(1, 1'b1, 60);
		setp(6, 1'b0);
		idle(10);
		@(posedge mclk);
		restart <= 1'b1;
		@(posedge mclk);
		restart <= 1'b0;
		idle(60);
		cmp({lock, hcab, ind}, 10'h0);
		$display("supplies normal test done");
		end_of_test;
	end
endmodule
